// File: src/tpsc_map.svh
`ifndef TPSC_MAP_SVH
`define TPSC_MAP_SVH

// Register indices; byte address is four times the index
`define TPSC_IDX_RUN_CONTROL    3'h0
`define TPSC_IDX_RUN_STATUS     3'h1
`define TPSC_IDX_FRAME_WIDTH    3'h2
`define TPSC_IDX_FRAME_HEIGHT   3'h3
`define TPSC_IDX_COLOUR_FIRST   3'h4
`define TPSC_IDX_COLOUR_SECOND  3'h5
`define TPSC_IDX_COLOUR_THIRD   3'h6

// Field positions
`define TPSC_RUN_BIT            0
`define TPSC_STATUS_BIT         0

// Reset values
`define TPSC_RST_RUN            1'b0
`define TPSC_RST_WIDTH          16'h0020
`define TPSC_RST_HEIGHT         16'h0020
`define TPSC_RST_COLOUR         16'h0000

// Stream packet codes
`define TPSC_TYPE_CTRL          4'hF
`define TPSC_TYPE_IMAGE         4'h0
`define TPSC_SCAN_PROG          4'h0
`define TPSC_SCAN_FIELD0        4'h8
`define TPSC_SCAN_FIELD1        4'hC

// Bus answers
`define TPSC_RESP_OKAY          2'h0
`define TPSC_RESP_SLVERR        2'h2

`endif

// File: src/tpsc_pkg.sv
package tpsc_pkg;

  typedef enum logic [2:0] {
    SEQ_IDLE  = 3'b001,
    SEQ_START = 3'b010,
    SEQ_RUN   = 3'b100
  } tpsc_seq_state_t;

  typedef enum logic [4:0] {
    GEN_IDLE      = 5'b00001,
    GEN_CTRL_HDR  = 5'b00010,
    GEN_CTRL_BODY = 5'b00100,
    GEN_IMG_HDR   = 5'b01000,
    GEN_PIX       = 5'b10000
  } tpsc_gen_state_t;

  typedef struct packed {
    logic        run;
    logic [15:0] width;
    logic [15:0] height;
    logic [15:0] c_first;
    logic [15:0] c_second;
    logic [15:0] c_third;
  } tpsc_ctrl_t;

  typedef struct packed {
    tpsc_gen_state_t state;
    logic [15:0]     x;
    logic [15:0]     y;
    logic            valid;
    logic            sop;
    logic            eop;
    logic [47:0]     data;
    logic            done;
  } tpsc_gen_t;

endpackage

// File: src/tpsc_pkt_if.sv
interface tpsc_pkt_if;
  logic        start;
  logic [15:0] width;
  logic [15:0] lines;
  logic [3:0]  scan;
  logic [15:0] c_first;
  logic [15:0] c_second;
  logic [15:0] c_third;
  logic        done;

  modport seq (output start, width, lines, scan, c_first, c_second, c_third, input done);
  modport gen (input start, width, lines, scan, c_first, c_second, c_third, output done);
endinterface

// File: src/tpsc_pkt_gen.sv
`include "tpsc_map.svh"

module tpsc_pkt_gen
  import tpsc_pkg::*;
(
  input  wire logic        aclk,      // Clock
  input  wire logic        aresetn,   // Synchronous reset, active low
  tpsc_pkt_if.gen          pkt,       // Field request from the sequencer
  output logic             vid_valid, // Stream beat valid
  input  wire logic        vid_ready, // Stream beat accepted
  output logic [47:0]      vid_data,  // Stream beat data
  output logic             vid_sop,   // First beat of packet
  output logic             vid_eop    // Last beat of packet
);

  tpsc_gen_t q;
  tpsc_gen_t d;

  logic fire;
  logic last_x;
  logic last_y;

  always_comb
  begin
    d      = q;
    d.done = 1'b0;
    fire   = !q.valid || vid_ready;
    last_x = (q.x == pkt.width - 16'h0001);
    last_y = (q.y == pkt.lines - 16'h0001);
    if (fire)
    begin
      unique case (q.state)
        GEN_IDLE:
        begin
          d.valid = 1'b0;
          if (pkt.start)
          begin
            d.state = GEN_CTRL_HDR;
            d.valid = 1'b1;
            d.sop   = 1'b1;
            d.eop   = 1'b0;
            d.data  = {44'h0_0000_0000_0, `TPSC_TYPE_CTRL};
          end
        end
        GEN_CTRL_HDR:
        begin
          // Describes the image packet that follows
          d.state = GEN_CTRL_BODY;
          d.sop   = 1'b0;
          d.eop   = 1'b1;
          d.data  = {12'h000, pkt.scan, pkt.lines, pkt.width};
        end
        GEN_CTRL_BODY:
        begin
          d.state = GEN_IMG_HDR;
          d.sop   = 1'b1;
          d.eop   = 1'b0;
          d.data  = {44'h0_0000_0000_0, `TPSC_TYPE_IMAGE};
        end
        GEN_IMG_HDR:
        begin
          d.state = GEN_PIX;
          d.x     = 16'h0000;
          d.y     = 16'h0000;
          d.sop   = 1'b0;
          d.eop   = (pkt.width == 16'h0001) && (pkt.lines == 16'h0001);
          d.data  = {pkt.c_third, pkt.c_second, pkt.c_first};
        end
        GEN_PIX:
        begin
          if (last_x && last_y)
          begin
            d.state = GEN_IDLE;
            d.valid = 1'b0;
            d.eop   = 1'b0;
            d.done  = 1'b1;
          end
          else
          begin
            if (last_x)
            begin
              d.x = 16'h0000;
              d.y = q.y + 16'h0001;
            end
            else
            begin
              d.x = q.x + 16'h0001;
            end
            d.eop = (d.x == pkt.width - 16'h0001) && (d.y == pkt.lines - 16'h0001);
          end
        end
        default:
        begin
          d.state = GEN_IDLE;
          d.valid = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q       <= '0;
      q.state <= GEN_IDLE;
    end
    else
    begin
      q <= d;
    end
  end

  assign vid_valid = q.valid;
  assign vid_data  = q.data;
  assign vid_sop   = q.sop;
  assign vid_eop   = q.eop;
  assign pkt.done  = q.done;

endmodule

// File: src/tpsc_top.sv
// Added by the designer: the AXI4-Lite slave port.
`include "tpsc_map.svh"

// Behaviour
// - All control registers are 16 bits wide
// - Sample registers once per frame, hold copy
// - Control packet describes the following image packet
// - Interlaced: sample before first field only
// - Run bit at offset 0; cleared stops
// - Status bit high while producing a frame
// - Width at offset 2, 32 to maximum; not enforced, any written value is stored
// - Height at offset 3, 32 to maximum; not enforced, any written value is stored
// - Uniform colour from offsets 4, 5, 6
// - Colour registers exist only when enabled
module tpsc_top
  import tpsc_pkg::*;
#(
  parameter int MAX_WIDTH      = 1920, // Largest width intended for software; unused by the logic
  parameter int MAX_HEIGHT     = 1080, // Largest height intended for software; unused by the logic
  parameter bit INTERLACED     = 1'b0, // Output as field pairs
  parameter bit COLOUR_REGS_EN = 1'b1  // Uniform colour with run-time control
)
(
  input  wire logic        aclk,          // Clock, 125 MHz
  input  wire logic        aresetn,       // Synchronous reset, active low
  input  wire logic [4:0]  s_axi_awaddr,  // Write address
  input  wire logic [2:0]  s_axi_awprot,  // Write protection, ignored
  input  wire logic        s_axi_awvalid, // Write address valid
  output logic             s_axi_awready, // Write address ready
  input  wire logic [31:0] s_axi_wdata,   // Write data
  input  wire logic [3:0]  s_axi_wstrb,   // Write byte strobes
  input  wire logic        s_axi_wvalid,  // Write data valid
  output logic             s_axi_wready,  // Write data ready
  output logic [1:0]       s_axi_bresp,   // Write response
  output logic             s_axi_bvalid,  // Write response valid
  input  wire logic        s_axi_bready,  // Write response ready
  input  wire logic [4:0]  s_axi_araddr,  // Read address
  input  wire logic [2:0]  s_axi_arprot,  // Read protection, ignored
  input  wire logic        s_axi_arvalid, // Read address valid
  output logic             s_axi_arready, // Read address ready
  output logic [31:0]      s_axi_rdata,   // Read data
  output logic [1:0]       s_axi_rresp,   // Read response
  output logic             s_axi_rvalid,  // Read data valid
  input  wire logic        s_axi_rready,  // Read data ready
  output logic             vid_valid,     // Stream beat valid
  input  wire logic        vid_ready,     // Stream beat accepted by sink
  output logic [47:0]      vid_data,      // Stream beat: third, second, first sample
  output logic             vid_sop,       // First beat of packet
  output logic             vid_eop        // Last beat of packet
);

  typedef struct packed {
    logic            aw_held;
    logic [2:0]      aw_idx;
    logic            w_held;
    logic [15:0]     w_data;
    logic [1:0]      w_strb;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            rvalid;
    logic [15:0]     rdata;
    logic [1:0]      rresp;
    tpsc_ctrl_t      regs;
    tpsc_ctrl_t      shadow;
    tpsc_seq_state_t state;
    logic            field;
    logic            start;
  } tpsc_top_t;

  tpsc_top_t q;
  tpsc_top_t d;

  tpsc_pkt_if pkt ();

  logic        status_bit;
  logic        wr_go;
  logic        wr_mapped;
  logic        rd_mapped;
  logic [2:0]  ar_idx;
  logic [15:0] rd_val;
  logic [15:0] wr_merged;
  logic [15:0] wr_old;

  function automatic logic idx_mapped(input logic [2:0] idx);
    logic ok;
    ok = (idx <= `TPSC_IDX_FRAME_HEIGHT);
    if (COLOUR_REGS_EN && (idx >= `TPSC_IDX_COLOUR_FIRST) && (idx <= `TPSC_IDX_COLOUR_THIRD))
    begin
      ok = 1'b1;
    end
    return ok;
  endfunction

  assign status_bit = (q.state != SEQ_IDLE);
  assign ar_idx     = s_axi_araddr[4:2];

  // Register read multiplexer
  always_comb
  begin
    rd_val    = 16'h0000;
    rd_mapped = idx_mapped(ar_idx);
    unique case (ar_idx)
      `TPSC_IDX_RUN_CONTROL:   rd_val[`TPSC_RUN_BIT] = q.regs.run;
      `TPSC_IDX_RUN_STATUS:    rd_val[`TPSC_STATUS_BIT] = status_bit;
      `TPSC_IDX_FRAME_WIDTH:   rd_val = q.regs.width;
      `TPSC_IDX_FRAME_HEIGHT:  rd_val = q.regs.height;
      `TPSC_IDX_COLOUR_FIRST:  rd_val = COLOUR_REGS_EN ? q.regs.c_first : 16'h0000;
      `TPSC_IDX_COLOUR_SECOND: rd_val = COLOUR_REGS_EN ? q.regs.c_second : 16'h0000;
      `TPSC_IDX_COLOUR_THIRD:  rd_val = COLOUR_REGS_EN ? q.regs.c_third : 16'h0000;
      default:                 rd_val = 16'h0000;
    endcase
  end

  // Current value of the write target, for byte-lane merging
  always_comb
  begin
    wr_old = 16'h0000;
    unique case (q.aw_idx)
      `TPSC_IDX_RUN_CONTROL:   wr_old[`TPSC_RUN_BIT] = q.regs.run;
      `TPSC_IDX_FRAME_WIDTH:   wr_old = q.regs.width;
      `TPSC_IDX_FRAME_HEIGHT:  wr_old = q.regs.height;
      `TPSC_IDX_COLOUR_FIRST:  wr_old = q.regs.c_first;
      `TPSC_IDX_COLOUR_SECOND: wr_old = q.regs.c_second;
      `TPSC_IDX_COLOUR_THIRD:  wr_old = q.regs.c_third;
      default:                 wr_old = 16'h0000;
    endcase
    wr_merged = {q.w_strb[1] ? q.w_data[15:8] : wr_old[15:8],
                 q.w_strb[0] ? q.w_data[7:0] : wr_old[7:0]};
  end

  assign wr_go     = q.aw_held && q.w_held && !q.bvalid;
  assign wr_mapped = idx_mapped(q.aw_idx);

  always_comb
  begin
    d       = q;
    d.start = 1'b0;

    // Write address and data are taken independently
    if (s_axi_awvalid && !q.aw_held)
    begin
      d.aw_held = 1'b1;
      d.aw_idx  = s_axi_awaddr[4:2];
    end
    if (s_axi_wvalid && !q.w_held)
    begin
      d.w_held = 1'b1;
      d.w_data = s_axi_wdata[15:0];
      d.w_strb = s_axi_wstrb[1:0];
    end

    if (wr_go)
    begin
      d.aw_held = 1'b0;
      d.w_held  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = wr_mapped ? `TPSC_RESP_OKAY : `TPSC_RESP_SLVERR;
      if (wr_mapped)
      begin
        unique case (q.aw_idx)
          `TPSC_IDX_RUN_CONTROL:   d.regs.run = wr_merged[`TPSC_RUN_BIT];
          `TPSC_IDX_FRAME_WIDTH:   d.regs.width = wr_merged;
          `TPSC_IDX_FRAME_HEIGHT:  d.regs.height = wr_merged;
          `TPSC_IDX_COLOUR_FIRST:  d.regs.c_first = wr_merged;
          `TPSC_IDX_COLOUR_SECOND: d.regs.c_second = wr_merged;
          `TPSC_IDX_COLOUR_THIRD:  d.regs.c_third = wr_merged;
          default:                 d.regs = q.regs;
        endcase
      end
    end
    else if (q.bvalid && s_axi_bready)
    begin
      d.bvalid = 1'b0;
    end

    // Read answer follows the address by one cycle
    if (s_axi_arvalid && !q.rvalid)
    begin
      d.rvalid = 1'b1;
      d.rdata  = rd_val;
      d.rresp  = rd_mapped ? `TPSC_RESP_OKAY : `TPSC_RESP_SLVERR;
    end
    else if (q.rvalid && s_axi_rready)
    begin
      d.rvalid = 1'b0;
    end

    // Frame sequencer
    unique case (q.state)
      SEQ_IDLE:
      begin
        // Stop point lies before the control values are taken
        if (q.regs.run)
        begin
          d.shadow = q.regs;
          d.field  = 1'b0;
          d.state  = SEQ_START;
        end
      end
      SEQ_START:
      begin
        d.start = 1'b1;
        d.state = SEQ_RUN;
      end
      SEQ_RUN:
      begin
        if (pkt.done)
        begin
          if (INTERLACED && !q.field)
          begin
            // Second field reuses the copy taken for the first
            d.field = 1'b1;
            d.state = SEQ_START;
          end
          else
          begin
            d.state = SEQ_IDLE;
          end
        end
      end
      default:
      begin
        d.state = SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q                 <= '0;
      q.state           <= SEQ_IDLE;
      q.regs.run        <= `TPSC_RST_RUN;
      q.regs.width      <= `TPSC_RST_WIDTH;
      q.regs.height     <= `TPSC_RST_HEIGHT;
      q.regs.c_first    <= `TPSC_RST_COLOUR;
      q.regs.c_second   <= `TPSC_RST_COLOUR;
      q.regs.c_third    <= `TPSC_RST_COLOUR;
      q.shadow.width    <= `TPSC_RST_WIDTH;
      q.shadow.height   <= `TPSC_RST_HEIGHT;
    end
    else
    begin
      q <= d;
    end
  end

  // Field geometry from the held copy only
  always_comb
  begin
    pkt.start    = q.start;
    pkt.width    = q.shadow.width;
    pkt.c_first  = COLOUR_REGS_EN ? q.shadow.c_first : 16'h0000;
    pkt.c_second = COLOUR_REGS_EN ? q.shadow.c_second : 16'h0000;
    pkt.c_third  = COLOUR_REGS_EN ? q.shadow.c_third : 16'h0000;
    if (!INTERLACED)
    begin
      pkt.lines = q.shadow.height;
      pkt.scan  = `TPSC_SCAN_PROG;
    end
    else if (!q.field)
    begin
      pkt.lines = q.shadow.height - (q.shadow.height >> 1);
      pkt.scan  = `TPSC_SCAN_FIELD0;
    end
    else
    begin
      pkt.lines = q.shadow.height >> 1;
      pkt.scan  = `TPSC_SCAN_FIELD1;
    end
  end

  tpsc_pkt_gen u_gen (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .pkt       (pkt),
    .vid_valid (vid_valid),
    .vid_ready (vid_ready),
    .vid_data  (vid_data),
    .vid_sop   (vid_sop),
    .vid_eop   (vid_eop)
  );

  assign s_axi_awready = !q.aw_held;
  assign s_axi_wready  = !q.w_held;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rresp   = q.rresp;
  assign s_axi_rdata   = {16'h0000, q.rdata};

endmodule

// File: test/tpsc_chk.sv
`include "tpsc_map.svh"

module tpsc_chk
#(
  parameter bit INTERLACED = 1'b0 // Field pairs with alternating scan codes
)
(
  input wire logic        aclk,          // Clock
  input wire logic        aresetn,       // Reset, active low
  input wire logic [4:0]  s_axi_araddr,  // Read address
  input wire logic        s_axi_arvalid, // Read address valid
  input wire logic        s_axi_arready, // Read address ready
  input wire logic [31:0] s_axi_rdata,   // Read data
  input wire logic [1:0]  s_axi_rresp,   // Read response
  input wire logic        s_axi_rvalid,  // Read data valid
  input wire logic        vid_valid,     // Beat valid
  input wire logic        vid_ready,     // Beat accepted
  input wire logic [47:0] vid_data,      // Beat data
  input wire logic        vid_sop,       // First beat
  input wire logic        vid_eop        // Last beat
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        acc;
  logic        ctrl_q;
  logic        img_q;
  logic        pix_q;
  logic        fld_q;
  logic [31:0] cnt_q;
  logic [15:0] w_q;
  logic [15:0] l_q;
  logic [47:0] col_q;
  assign acc = vid_valid && vid_ready;
  // Tracks where in the control and image packets the stream is
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q <= 1'b0;
      img_q  <= 1'b0;
      pix_q  <= 1'b0;
      fld_q  <= 1'b0;
      cnt_q  <= 32'h0000_0000;
      w_q    <= 16'h0000;
      l_q    <= 16'h0000;
      col_q  <= 48'h0000_0000_0000;
    end
    else if (acc)
    begin
      ctrl_q <= vid_sop && vid_data[3:0] == `TPSC_TYPE_CTRL;
      if (ctrl_q)
      begin
        img_q <= 1'b1;
        w_q   <= vid_data[15:0];
        l_q   <= vid_data[31:16];
        fld_q <= INTERLACED && !fld_q;
      end
      if (vid_sop && img_q)
      begin
        img_q <= 1'b0;
        pix_q <= 1'b1;
        cnt_q <= 32'h0000_0000;
      end
      else if (pix_q)
      begin
        cnt_q <= cnt_q + 32'h0000_0001;
        if (cnt_q == 32'h0000_0000)
          col_q <= vid_data;
        if (vid_eop)
          pix_q <= 1'b0;
      end
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_ctrl_hdr;
    acc && vid_sop && vid_data[3:0] == `TPSC_TYPE_CTRL;
  endsequence
  a_rdata_width: assert property (s_ar_taken |=> s_axi_rvalid && s_axi_rdata[31:16] == 16'h0000)
    else $error("Read data has bits above 15");
  a_status_bits: assert property (s_ar_taken ##0 s_axi_araddr[4:2] == 3'h1 |=> s_axi_rdata[31:1] == '0)
    else $error("Status read has bits above 0");
  a_colour_present: assert property (s_ar_taken ##0 s_axi_araddr[4:2] inside {[3'h4:3'h6]}
    |=> s_axi_rvalid && s_axi_rresp == `TPSC_RESP_OKAY) else $error("Colour register refused");
  a_unmapped_err: assert property (s_ar_taken ##0 s_axi_araddr[4:2] == 3'h7
    |=> s_axi_rresp == `TPSC_RESP_SLVERR && s_axi_rdata == '0) else $error("Unmapped read accepted");
  a_hdr_single: assert property (s_ctrl_hdr |-> !vid_eop)
    else $error("Control header ends packet");
  a_ctrl_body: assert property (acc && ctrl_q |-> vid_eop && !vid_sop
    && vid_data[35:32] == (!INTERLACED ? `TPSC_SCAN_PROG
    : fld_q ? `TPSC_SCAN_FIELD1 : `TPSC_SCAN_FIELD0)) else $error("Control body malformed");
  a_img_follows: assert property (acc && vid_sop && img_q |-> vid_data[3:0] == `TPSC_TYPE_IMAGE)
    else $error("Image packet does not follow control packet");
  a_pix_count: assert property (acc && pix_q && vid_eop |-> cnt_q + 32'h0000_0001 == w_q * l_q)
    else $error("Image pixel count differs from control packet");
  a_pix_colour: assert property (acc && pix_q && cnt_q != 0 |-> vid_data == col_q && !vid_sop)
    else $error("Pixel colour changed within frame");
  a_beat_hold: assert property (vid_valid && !vid_ready |=> vid_valid && $stable(vid_data))
    else $error("Beat withdrawn before acceptance");
endmodule

bind tpsc_top tpsc_chk #(.INTERLACED(INTERLACED)) chk_u
(
  .aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .vid_valid, .vid_ready, .vid_data, .vid_sop, .vid_eop
);

// File: test/tpsc_sink.sv
module tpsc_sink
(
  input wire logic aclk,     // Clock
  input wire logic aresetn,  // Reset, active low
  input wire logic slow,     // Stall at random when high
  output logic     vid_ready // Beat accepted
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] lfsr_q;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      lfsr_q    <= 16'hACE1;
      vid_ready <= 1'b0;
    end
    else
    begin
      lfsr_q    <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
      vid_ready <= !slow || lfsr_q[0];
    end
  end
endmodule

// File: test/tb_top.sv
`include "tpsc_map.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [49:0] d; logic [49:0] m;} tpsc_exp_t;
  localparam logic [49:0] HDR_M = {2'b11, 44'h0, 4'hF};
  logic        aclk = 1'b0, aresetn = 1'b0, slow = 1'b1;
  logic [4:0]  s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
  logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        vid_valid, vid_ready, vid_sop, vid_eop;
  logic        vi_valid, vi_sop, vi_eop;
  logic [47:0] vid_data, vi_data, px;
  logic [31:0] rs = 32'h6f52_cf1f;
  int          error_cnt = 0;
  int          n_compared = 0;
  tpsc_exp_t   vq[$], iq[$], rq[$], bq[$];

  tpsc_top dut_u
  (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .vid_valid, .vid_ready,
    .vid_data, .vid_sop, .vid_eop
  );
  // Interlaced copy on the same bus and sink; only its stream is watched
  tpsc_top #(.INTERLACED(1'b1)) dut_il
  (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready (),
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready (), .s_axi_bresp (),
    .s_axi_bvalid (), .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready (), .s_axi_rdata (), .s_axi_rresp (), .s_axi_rvalid (), .s_axi_rready,
    .vid_valid (vi_valid), .vid_ready, .vid_data (vi_data), .vid_sop (vi_sop),
    .vid_eop (vi_eop)
  );
  tpsc_sink sink_u (.aclk, .aresetn, .slow, .vid_ready);

  initial
  begin
    forever #4 aclk = ~aclk;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic report(input logic [49:0] e, input logic [49:0] g);
    error_cnt++;
    $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
  endtask

  task automatic chk(input tpsc_exp_t e, input logic [49:0] g);
    n_compared++;
    if ((g & e.m) !== (e.d & e.m))
      report(e.d & e.m, g & e.m);
  endtask

  // Results are matched against the oldest note as they appear
  always @(posedge aclk)
  begin
    if (vid_valid && vid_ready)
      if (vq.size() == 0)
        report(50'h0, {vid_sop, vid_eop, vid_data});
      else
        chk(vq.pop_front(), {vid_sop, vid_eop, vid_data});
    if (vi_valid && vid_ready)
      if (iq.size() == 0)
        report(50'h0, {vi_sop, vi_eop, vi_data});
      else
        chk(iq.pop_front(), {vi_sop, vi_eop, vi_data});
    if (s_axi_rvalid && s_axi_rready)
      chk(rq.pop_front(), {16'h0, s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid && s_axi_bready)
      chk(bq.pop_front(), {48'h0, s_axi_bresp});
  end

  task automatic wr(input logic [2:0] idx, input logic [31:0] d, input logic [1:0] r);
    bq.push_back('{{48'h0, r}, 50'h3});
    s_axi_awaddr  <= {idx, 2'b00};
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready)
      begin
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr  <= ~s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        s_axi_wvalid <= 1'b0;
        s_axi_wdata  <= ~s_axi_wdata;
      end
    end
    while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [2:0] idx, input logic [31:0] d, input logic [1:0] r);
    rq.push_back('{{16'h0, r, d}, '1});
    s_axi_araddr  <= {idx, 2'b00};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arvalid <= 1'b0;
        s_axi_araddr  <= ~s_axi_araddr;
      end
    end
    while (!(s_axi_rvalid && s_axi_rready));
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  // New random colours, upper halves of the words carry noise
  task automatic colours();
    for (int i = 0; i < 3; i++)
    begin
      rs = xs(rs);
      px[16*i +: 16] = rs[15:0];
      wr(3'(4 + i), rs, `TPSC_RESP_OKAY);
    end
  endtask

  task automatic note(input bit il, input tpsc_exp_t e);
    if (il)
      iq.push_back(e);
    else
      vq.push_back(e);
  endtask

  task automatic exp_field(input bit il, input logic [3:0] s, input logic [15:0] w,
                           input logic [15:0] l);
    int n;
    n = w * l;
    note(il, '{{2'b10, 44'h0, `TPSC_TYPE_CTRL}, HDR_M});
    note(il, '{{2'b01, 12'h0, s, l, w}, {2'b11, 12'h0, 36'hF_FFFF_FFFF}});
    note(il, '{{2'b10, 44'h0, `TPSC_TYPE_IMAGE}, HDR_M});
    for (int i = 1; i <= n; i++)
      note(il, '{{1'b0, i == n, px}, '1});
  endtask

  // The interlaced copy sends the same frame as two fields, one sampling
  task automatic exp_frame(input logic [15:0] w, input logic [15:0] h);
    exp_field(1'b0, `TPSC_SCAN_PROG, w, h);
    exp_field(1'b1, `TPSC_SCAN_FIELD0, w, (h + 16'h0001) >> 1);
    exp_field(1'b1, `TPSC_SCAN_FIELD1, w, h >> 1);
  endtask

  task automatic run_frame();
    wr(3'h0, 32'h0000_0001, `TPSC_RESP_OKAY);
    while (!vid_valid)
      @(posedge aclk);
  endtask

  task automatic end_frame();
    while (vq.size() != 0 || iq.size() != 0)
      @(posedge aclk);
    repeat (40) @(posedge aclk);
    rd(3'h1, 32'h0000_0000, `TPSC_RESP_OKAY);
  endtask

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge aclk);
    report(50'h1, 50'h0);
    wrap_up();
  end

  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 7; i++)
      rd(3'(i), (i == 2) ? {16'h0, `TPSC_RST_WIDTH} :
         (i == 3) ? {16'h0, `TPSC_RST_HEIGHT} : 32'h0, `TPSC_RESP_OKAY);
    rd(3'h7, 32'h0000_0000, `TPSC_RESP_SLVERR);
    wr(3'h7, 32'hFFFF_FFFF, `TPSC_RESP_SLVERR);
    wr(3'h1, 32'hFFFF_FFFF, `TPSC_RESP_OKAY);
    wr(3'h0, 32'hFFFF_FFFE, `TPSC_RESP_OKAY);
    rd(3'h1, 32'h0000_0000, `TPSC_RESP_OKAY);
    rd(3'h0, 32'h0000_0000, `TPSC_RESP_OKAY);
    $display("test register map done");
    colours();
    wr(3'h2, 32'hABCD_0028, `TPSC_RESP_OKAY);
    wr(3'h3, 32'h0000_0021, `TPSC_RESP_OKAY);
    rd(3'h2, 32'h0000_0028, `TPSC_RESP_OKAY);
    exp_frame(16'h0028, 16'h0021);
    run_frame();
    colours();
    wr(3'h2, 32'h0000_0020, `TPSC_RESP_OKAY);
    wr(3'h3, 32'h0000_0020, `TPSC_RESP_OKAY);
    wr(3'h0, 32'h0000_0000, `TPSC_RESP_OKAY);
    rd(3'h1, 32'h0000_0001, `TPSC_RESP_OKAY);
    end_frame();
    $display("test frame with slow sink done");
    slow <= 1'b0;
    exp_frame(16'h0020, 16'h0020);
    run_frame();
    wr(3'h0, 32'h0000_0000, `TPSC_RESP_OKAY);
    end_frame();
    $display("test frame with prompt sink done");
    wrap_up();
  end
endmodule
